// ==== hw/mtt_cfg.svh ====
// Constants of the modulo timer with toggle output.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef MTT_CFG_SVH
`define MTT_CFG_SVH
// Register indices; byte address is four times the index
`define MTT_IDX_CTRL 6'h12
`define MTT_IDX_MODULO 6'h13
`define MTT_IDX_COUNT 6'h14
`define MTT_IDX_STATUS 6'h15
`define MTT_IDX_MASK 6'h16
// Control field positions
`define MTT_BIT_OUTSEL 0
`define MTT_BIT_RUN 1
`define MTT_BIT_CLEAR 2
`define MTT_BIT_SRC_LO 4
`define MTT_BIT_SRC_HI 5
// Status and mask field positions
`define MTT_BIT_MATCH 0
// Prescaler taps as powers of two of the system clock
`define MTT_LOG_DIV32 5
`define MTT_LOG_DIV256 8
`define MTT_LOG_DIV2048 11
// Reset values
`define MTT_RST_TOGGLE 1'b1
`define MTT_RST_BYTE 8'h00
`define MTT_RST_SRC 2'h0
`endif

// ==== hw/mtt_pkg.sv ====
// Types shared by the modulo timer and its bench.
// Assumes mtt_cfg.svh on the include path.
`include "mtt_cfg.svh"
package mtt_pkg;
    // Count source codes
    typedef enum logic [1:0] {
        SRC_DIV256 = 2'h0,
        SRC_DIV32 = 2'h1,
        SRC_DIV2048 = 2'h2,
        SRC_EXT = 2'h3
    } mtt_src_t;
    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } mtt_avm_cmd_t;
    // Avalon-MM answer to the master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } mtt_avm_rsp_t;
endpackage

// ==== hw/mtt_timer.sv ====
// 8-bit modulo timer with a toggling match output on an open-drain pin.
// Assumes an Avalon-MM master on ref_clk and an asynchronous external count pin.
//
// Notes on behaviour
// R01: The timer is an 8-bit counter, an 8-bit modulo register and a count source selector.
// R02: The counter is compared with the modulo value at all times and equality means a match.
// R03: The modulo register can only be written; reading it gives zero.
// R04: The counter can only be read; writes do not touch the count.
// R05: Source 00 is clock/256, 01 clock/32, 10 clock/2048, 11 the external count pin.
// R06: With output select at 1 the toggle flop drives the shared pin, ignoring its direction bit.
// R07: Each match inverts the toggle flop once.
// R08: The pin is open drain: pulled low for 0, released for 1.
// R09: The toggle flop stays still until the run bit is 1 and toggles from then on.
// R10: Writing 1 to the clear bit returns the toggle flop to its initial value.
// R11: With output select at 1, a clear shows 1 on the output before any match.
// R12: Output select sits at bit 0 of register index 12h.
// R13: A match clears the counter to zero and counting goes on, a period of modulo plus one.
`include "mtt_cfg.svh"
module mtt_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register bus
    input wire mtt_pkg::mtt_avm_cmd_t avs_cmd,
    output mtt_pkg::mtt_avm_rsp_t avs_rsp,
    // External count input
    input wire logic ext_count_pin,
    // Shared open-drain pin
    input wire logic shared_port_pin_in,
    output logic shared_port_pin_out,
    output logic shared_port_pin_oe,
    // Toggle state and interrupt
    output logic match_toggle_out,
    output logic irq
);
    // Reset release and pin synchronisers
    logic rst_meta_q, rst_sync_q;
    logic ext_meta_q, ext_sync_q, ext_last_q;
    // Register state
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic match_out_select_q, match_out_select_d;
    logic timer_run_bit_q, timer_run_bit_d;
    mtt_pkg::mtt_src_t src_q, src_d;
    logic [7:0] modulo_q, modulo_d;
    logic status_q, status_d;
    logic mask_q, mask_d;
    // Timer state
    logic [`MTT_LOG_DIV2048-1:0] pre_q, pre_d;
    logic [7:0] count_q, count_d;
    logic toggle_q, toggle_d;
    logic oe_q, oe_d;
    logic irq_q, irq_d;
    // Decode and events
    logic [5:0] idx;
    logic take, do_wr, clear_hit, tick, match_eq, match_hit;

    // Asynchronous assert, synchronous release of reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Count pin crosses in through two flops; edge found after them
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_last_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_count_pin;
            ext_sync_q <= ext_meta_q;
            ext_last_q <= ext_sync_q;
        end
    end

    // Bus decode: an access completes at the edge that sees waitrequest low
    assign idx = avs_cmd.address[7:2];
    assign take = (avs_cmd.read | avs_cmd.write) & wait_q;
    assign do_wr = avs_cmd.write & ~wait_q;
    assign clear_hit = do_wr & (idx == `MTT_IDX_CTRL) & avs_cmd.writedata[`MTT_BIT_CLEAR];

    // Prescaler taps and source selection
    always_comb begin
        case (src_q) // [R05]
            mtt_pkg::SRC_DIV256: tick = &pre_q[`MTT_LOG_DIV256-1:0];
            mtt_pkg::SRC_DIV32: tick = &pre_q[`MTT_LOG_DIV32-1:0];
            mtt_pkg::SRC_DIV2048: tick = &pre_q;
            mtt_pkg::SRC_EXT: tick = ext_sync_q & ~ext_last_q;
            default: tick = 1'b0;
        endcase
    end

    // Comparator is continuous; only a counted match acts
    assign match_eq = (count_q == modulo_q); // [R02]
    assign match_hit = match_eq & tick & timer_run_bit_q; // [R09]

    // Next values of bus, registers and timer
    always_comb begin
        wait_d = ~take;
        rdata_d = rdata_q;
        match_out_select_d = match_out_select_q;
        timer_run_bit_d = timer_run_bit_q;
        src_d = src_q;
        modulo_d = modulo_q;
        mask_d = mask_q;
        status_d = status_q;
        pre_d = pre_q + 1'b1;
        count_d = count_q;
        toggle_d = toggle_q;
        // Read data latched on acceptance, ready with waitrequest low
        if (take && avs_cmd.read) begin
            rdata_d = '0;
            case (idx)
                `MTT_IDX_CTRL: begin
                    rdata_d[`MTT_BIT_OUTSEL] = match_out_select_q;
                    rdata_d[`MTT_BIT_RUN] = timer_run_bit_q;
                    rdata_d[`MTT_BIT_SRC_HI:`MTT_BIT_SRC_LO] = src_q;
                end
                `MTT_IDX_MODULO: rdata_d = '0; // [R03]
                `MTT_IDX_COUNT: rdata_d[7:0] = count_q; // [R04]
                `MTT_IDX_STATUS: rdata_d[`MTT_BIT_MATCH] = status_q;
                `MTT_IDX_MASK: rdata_d[`MTT_BIT_MATCH] = mask_q;
                default: rdata_d = '0;
            endcase
        end
        // Writes; the count register has no write path
        if (do_wr) begin
            case (idx)
                `MTT_IDX_CTRL: begin
                    match_out_select_d = avs_cmd.writedata[`MTT_BIT_OUTSEL]; // [R12]
                    timer_run_bit_d = avs_cmd.writedata[`MTT_BIT_RUN];
                    src_d = mtt_pkg::mtt_src_t'(
                        avs_cmd.writedata[`MTT_BIT_SRC_HI:`MTT_BIT_SRC_LO]);
                end
                `MTT_IDX_MODULO: modulo_d = avs_cmd.writedata[7:0]; // [R03]
                `MTT_IDX_STATUS: begin
                    if (avs_cmd.writedata[`MTT_BIT_MATCH]) begin
                        status_d = 1'b0;
                    end
                end
                `MTT_IDX_MASK: mask_d = avs_cmd.writedata[`MTT_BIT_MATCH];
                default: begin
                end
            endcase
        end
        // Counter wraps to zero on match, else steps on each tick
        if (tick && timer_run_bit_q) begin
            count_d = match_eq ? 8'h00 : count_q + 8'h01; // [R13] [R01]
        end
        // Toggle on a match; a clear wins and restarts the prescaler
        if (match_hit) begin
            toggle_d = ~toggle_q; // [R07]
            status_d = 1'b1; // Set wins over a same-cycle clear
        end
        if (clear_hit) begin
            toggle_d = `MTT_RST_TOGGLE; // [R10] [R11]
            count_d = 8'h00;
            pre_d = '0;
        end
        oe_d = match_out_select_d & ~toggle_d; // [R06] [R08]
        irq_d = status_d & mask_d;
    end

    // Register every group
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            match_out_select_q <= 1'b0;
            timer_run_bit_q <= 1'b0;
            src_q <= mtt_pkg::SRC_DIV256;
            modulo_q <= `MTT_RST_BYTE;
            status_q <= 1'b0;
            mask_q <= 1'b0;
            pre_q <= '0;
            count_q <= `MTT_RST_BYTE;
            toggle_q <= `MTT_RST_TOGGLE;
            oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            match_out_select_q <= match_out_select_d;
            timer_run_bit_q <= timer_run_bit_d;
            src_q <= src_d;
            modulo_q <= modulo_d;
            status_q <= status_d;
            mask_q <= mask_d;
            pre_q <= pre_d;
            count_q <= count_d;
            toggle_q <= toggle_d;
            oe_q <= oe_d;
            irq_q <= irq_d;
        end
    end

    // Pin only ever pulls low, so output data is a constant zero
    assign shared_port_pin_out = 1'b0;
    assign shared_port_pin_oe = oe_q;
    assign match_toggle_out = toggle_q;
    assign irq = irq_q;
    assign avs_rsp.waitrequest = wait_q;
    assign avs_rsp.readdata = rdata_q;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_sync_q);

    sequence s_clear_write;
        avs_cmd.write && !wait_q && idx == `MTT_IDX_CTRL
            && avs_cmd.writedata[`MTT_BIT_CLEAR];
    endsequence
    sequence s_toggle_high;
        toggle_q && !shared_port_pin_oe;
    endsequence

    AST_COUNT_WIDTH: assert property ( // [R01]
        tick && timer_run_bit_q && !match_eq && !clear_hit |=> count_q == $past(count_q) + 8'h01)
        else $error("count did not step");
    AST_MATCH_EQ: assert property ( // [R02]
        match_hit && !clear_hit |=> toggle_q != $past(toggle_q))
        else $error("match seen but no toggle");
    AST_MODULO_WO: assert property ( // [R03]
        take && avs_cmd.read && idx == `MTT_IDX_MODULO |=> avs_rsp.readdata == 32'h0)
        else $error("modulo read not zero");
    AST_COUNT_RO: assert property ( // [R04]
        do_wr && idx == `MTT_IDX_COUNT && !(tick && timer_run_bit_q) && !clear_hit
            |=> $stable(count_q))
        else $error("count changed on write");
    AST_SRC_DIV32: assert property ( // [R05]
        src_q == mtt_pkg::SRC_DIV32 && tick |-> pre_q[`MTT_LOG_DIV32-1:0] == 5'h1f)
        else $error("div32 tick misplaced");
    AST_PIN_FOLLOWS: assert property ( // [R06]
        match_out_select_q && !$changed(match_out_select_q) && $stable(toggle_q)
            |-> shared_port_pin_oe == !toggle_q)
        else $error("pin not following toggle");
    AST_TOGGLE_ONCE: assert property ( // [R07]
        !match_hit && !clear_hit |=> $stable(toggle_q))
        else $error("toggle without match");
    AST_OPEN_DRAIN: assert property ( // [R08]
        shared_port_pin_out == 1'b0 && (!shared_port_pin_oe || !toggle_q))
        else $error("pin driven high");
    AST_IDLE: assert property ( // [R09]
        !timer_run_bit_q && !clear_hit |=> $stable(toggle_q) && $stable(count_q))
        else $error("timer moved while stopped");
    AST_CLEAR: assert property ( // [R10]
        s_clear_write |=> toggle_q == 1'b1 && count_q == 8'h00)
        else $error("clear failed");
    AST_CLEAR_OUT: assert property ( // [R11]
        s_clear_write ##1 match_out_select_q |-> s_toggle_high)
        else $error("output not released after clear");
    AST_SELECT_BIT: assert property ( // [R12]
        do_wr && idx == `MTT_IDX_CTRL
            |=> match_out_select_q == $past(avs_cmd.writedata[`MTT_BIT_OUTSEL]))
        else $error("select bit not stored");
    AST_WRAP: assert property ( // [R13]
        match_hit && !clear_hit |=> count_q == 8'h00)
        else $error("counter did not wrap");

    // Tap positions, single-cycle ticks, register stores, count read, prescaler clear and pin gating
    AST_SRC_DIV256: assert property ( // [R05]
        src_q == mtt_pkg::SRC_DIV256 && tick |-> pre_q[`MTT_LOG_DIV256-1:0] == 8'hff)
        else $error("div256 tick misplaced");
    AST_SRC_DIV2048: assert property ( // [R05]
        src_q == mtt_pkg::SRC_DIV2048 && tick |-> pre_q == 11'h7ff)
        else $error("div2048 tick misplaced");
    AST_EXT_SINGLE: assert property ( // [R05]
        src_q == mtt_pkg::SRC_EXT && tick ##1 src_q == mtt_pkg::SRC_EXT
            |-> !tick)
        else $error("pin edge counted twice");
    AST_DIV32_SINGLE: assert property ( // [R05]
        src_q == mtt_pkg::SRC_DIV32 && tick ##1 src_q == mtt_pkg::SRC_DIV32
            |-> !tick)
        else $error("div32 tick longer than a cycle");
    AST_SRC_STORE: assert property ( // [R05]
        do_wr && idx == `MTT_IDX_CTRL
            |=> src_q == $past(avs_cmd.writedata[`MTT_BIT_SRC_HI:`MTT_BIT_SRC_LO]))
        else $error("source not stored");
    AST_TOGGLE_NEEDS_EQ: assert property ( // [R02]
        $changed(toggle_q) && !$past(clear_hit) |-> $past(match_eq && tick && timer_run_bit_q))
        else $error("toggle without equal count");
    AST_MODULO_STORE: assert property ( // [R03]
        do_wr && idx == `MTT_IDX_MODULO |=> modulo_q == $past(avs_cmd.writedata[7:0]))
        else $error("modulo not stored");
    AST_COUNT_READ: assert property ( // [R04]
        take && avs_cmd.read && idx == `MTT_IDX_COUNT
            |=> avs_rsp.readdata == {24'h000000, $past(count_q)})
        else $error("count read wrong");
    AST_RUN_STORE: assert property ( // [R09]
        do_wr && idx == `MTT_IDX_CTRL
            |=> timer_run_bit_q == $past(avs_cmd.writedata[`MTT_BIT_RUN]))
        else $error("run bit not stored");
    AST_CLEAR_PRESCALER: assert property ( // [R10]
        s_clear_write |=> pre_q == '0)
        else $error("prescaler not cleared");
    AST_OE_SELECT_OFF: assert property ( // [R06]
        !match_out_select_q |-> !shared_port_pin_oe)
        else $error("pin driven with select off");
endmodule

// ==== tb/modulo_timer_toggle_output_bench.sv ====
// Self-checking bench for the modulo timer with toggle output.
// Assumes mtt_cfg.svh on the include path and the pull-up pin model.
`include "mtt_cfg.svh"
module modulo_timer_toggle_output_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_count_pin = 1'b0;
    mtt_pkg::mtt_avm_cmd_t cmd = '0;
    mtt_pkg::mtt_avm_rsp_t rsp;
    logic pin_out, pin_oe, pin_level, toggle, irq, held;
    logic [31:0] rd;
    logic [7:0] m;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 32'h4073;
    int per;
    mtt_pkg::mtt_src_t srcs [3] = '{mtt_pkg::SRC_DIV32, mtt_pkg::SRC_DIV256, mtt_pkg::SRC_DIV2048};

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // Design and its pin load
    mtt_timer dut (.ref_clk(ref_clk), .rstn(rstn), .avs_cmd(cmd), .avs_rsp(rsp),
        .ext_count_pin(ext_count_pin), .shared_port_pin_in(pin_level),
        .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe),
        .match_toggle_out(toggle), .irq(irq));
    mtt_pin_model load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

    // Expected match period in system clocks
    function automatic int period(input mtt_pkg::mtt_src_t s, input logic [7:0] mv);
        return (int'(mv) + 1) * (s == mtt_pkg::SRC_DIV32 ? 32
            : s == mtt_pkg::SRC_DIV256 ? 256 : 2048);
    endfunction

    // Control word from its fields
    function automatic logic [31:0] ctrl(input logic [1:0] s, input logic run, input logic clr);
        return (32'(s) << `MTT_BIT_SRC_LO) | (32'(clr) << `MTT_BIT_CLEAR)
            | (32'(run) << `MTT_BIT_RUN) | (32'h1 << `MTT_BIT_OUTSEL);
    endfunction

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        cmd.read <= ~wr;
        cmd.write <= wr;
        cmd.address <= {idx, 2'b00};
        cmd.writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        rd = rsp.readdata;
        cmd.read <= 1'b0;
        cmd.write <= 1'b0;
        if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    endtask

    // Counts clocks until the toggle output changes, bounded
    task wait_toggle(output int cyc);
        logic start;
        start = toggle;
        cyc = 0;
        while (toggle === start && cyc < 20000) begin
            @(negedge ref_clk);
            cyc++;
        end
        if (cyc >= 20000) chk("toggle wait", 32'h0, 32'h1);
    endtask

    // Slow external count pulse, well above the synchroniser delay
    task ext_pulse;
        @(posedge ref_clk);
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_count_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    task summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog sized well above the longest run
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("toggle", 32'(`MTT_RST_TOGGLE), 32'(toggle));
        chk("pin", 32'h1, 32'(pin_level));
        chk("irq", 32'h0, 32'(irq));
        $display("test reset done");
        bus(1'b1, `MTT_IDX_MODULO, 32'h5a);
        bus(1'b0, `MTT_IDX_MODULO, 32'h0);
        chk("modulo read", 32'h0, rd);
        bus(1'b1, `MTT_IDX_COUNT, 32'hff);
        bus(1'b0, `MTT_IDX_COUNT, 32'h0);
        chk("count read", 32'h0, rd);
        bus(1'b0, 6'h3f, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test access done");
        // Every internal source, random and boundary modulo values
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'($random(seed)) : (i == 1) ? 8'h00 : 8'($random(seed) & 1);
            bus(1'b1, `MTT_IDX_MODULO, 32'(m));
            bus(1'b1, `MTT_IDX_CTRL, ctrl(srcs[i], 1'b1, 1'b1));
            wait_toggle(per);
            wait_toggle(per);
            chk("period", 32'(period(srcs[i], m)), 32'(per));
            chk("pin level", 32'(toggle), 32'(pin_level));
        end
        bus(1'b1, `MTT_IDX_CTRL, ctrl(mtt_pkg::SRC_DIV32, 1'b0, 1'b0));
        held = toggle;
        repeat (300) @(negedge ref_clk);
        chk("frozen", 32'(held), 32'(toggle));
        bus(1'b1, `MTT_IDX_CTRL, ctrl(mtt_pkg::SRC_DIV32, 1'b0, 1'b1));
        repeat (2) @(negedge ref_clk);
        chk("cleared pin", 32'h1, 32'(pin_level));
        $display("test timing done");
        bus(1'b1, `MTT_IDX_MODULO, 32'h1);
        bus(1'b1, `MTT_IDX_CTRL, ctrl(mtt_pkg::SRC_EXT, 1'b1, 1'b1));
        ext_pulse();
        bus(1'b0, `MTT_IDX_COUNT, 32'h0);
        chk("ext count", 32'h1, rd);
        ext_pulse();
        chk("ext toggle", 32'h0, 32'(toggle));
        chk("pin low", 32'h0, 32'(pin_level));
        $display("test external done");
        bus(1'b1, `MTT_IDX_CTRL, 32'h0);
        repeat (2) @(negedge ref_clk);
        chk("oe off", 32'h0, 32'(pin_oe));
        // Toggle is low here, so a clear that fails leaves the pin pulled low
        bus(1'b1, `MTT_IDX_CTRL, ctrl(mtt_pkg::SRC_EXT, 1'b0, 1'b1));
        repeat (2) @(negedge ref_clk);
        chk("clear toggle", 32'(`MTT_RST_TOGGLE), 32'(toggle));
        chk("clear pin", 32'h1, 32'(pin_level));
        bus(1'b1, `MTT_IDX_MASK, 32'h1);
        repeat (2) @(negedge ref_clk);
        chk("irq set", 32'h1, 32'(irq));
        bus(1'b1, `MTT_IDX_STATUS, 32'h1);
        repeat (2) @(negedge ref_clk);
        chk("irq clear", 32'h0, 32'(irq));
        bus(1'b0, `MTT_IDX_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        $display("test interrupt done");
        summarize();
    end
endmodule

// ==== tb/mtt_pin_model.sv ====
// External load on the shared open-drain timer pin.
// Assumes the timer enables its driver only to pull the pin low.
module mtt_pin_model (
    // Driver side
    input wire logic pin_out,
    input wire logic pin_oe,
    // Resolved level
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up resistor wins when released, so a floating pin never reads unknown
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule
